//--- core/alof_core.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`default_nettype none

module alof_core
    import alof_pkg::*;
#(
    parameter int LATENCY = PIPE_LATENCY
)
(
    // clock, reset, enable
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    input  wire logic          clk_en,
    // sampling clock pins and control pins
    input  wire logic          sample_clock_true,
    input  wire logic          sample_clock_comp,
    input  wire logic          half_rate_select,
    input  wire logic          format_select,
    // quantizer result, same clock domain
    input  wire alof_smp_t     quant_in,
    // apb slave
    input  wire alof_apb_req_t apb_req,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // interrupt
    output logic               irq,
    // lvds output pairs
    output logic [7:0]         sample_word_pairs_true,
    output logic [7:0]         sample_word_pairs_comp,
    output logic               range_flag_true,
    output logic               range_flag_comp,
    output logic               data_clock_out_true,
    output logic               data_clock_out_comp
);

    // the pipeline needs at least one stage to hold a result
    if (LATENCY < 1)
    begin : g_bad_latency
        $error("alof_core: LATENCY must be at least 1");
    end

    // offset binary to twos complement differs only in the top bit
    function automatic logic [7:0] fmt_word(input logic [7:0] ob, input logic offs);
        logic [7:0] w;
        w = ob;
        if (!offs)
            w[MSB_POS] = ~ob[MSB_POS];
        return w;
    endfunction

    // clamp a result to its full scale code
    function automatic logic [7:0] sat_code(input alof_smp_t s);
        logic [7:0] c;
        c = s.code;
        if (s.over)
            c = CODE_TOP;
        else if (s.under)
            c = CODE_BOTTOM;
        return c;
    endfunction

    // two flop synchronisers for the pins; order: true, comp, half, fmt
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [1:0] clk_prev_r;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sync1_r    <= 4'h0;
            sync2_r    <= 4'h0;
            clk_prev_r <= 2'h0;
        end
        else if (clk_en)
        begin
            sync1_r    <= {format_select, half_rate_select, sample_clock_comp, sample_clock_true};
            sync2_r    <= sync1_r;
            clk_prev_r <= sync2_r[1:0];
        end
    end

    // edge decode on the synchronised clock pair
    wire clk_t_s    = sync2_r[0];
    wire clk_c_s    = sync2_r[1];
    wire full_rate  = sync2_r[2];
    wire offs_fmt   = sync2_r[3];
    wire rise_t     = clk_t_s & ~clk_prev_r[0];
    wire fall_c     = ~clk_c_s & clk_prev_r[1];
    wire fall_t     = ~clk_t_s & clk_prev_r[0];
    // a comp fall counts only together with a true rise, so the true rise alone marks the sample
    wire samp_edge  = rise_t | (fall_c & ~clk_prev_r[0] & clk_t_s);

    // divider, run gate and the taken-edge strobe
    logic div_r;
    logic run_r;
    // a low or floating select counts as divide by two
    wire  take      = samp_edge & run_r & (full_rate | div_r);
    wire  half_mode = ~full_rate;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            div_r <= 1'b0;
        else if (clk_en)
        begin
            if (full_rate)
                div_r <= 1'b0;
            else if (samp_edge)
                div_r <= ~div_r;
        end
    end

    // result pipeline: shifts once per taken edge, depth is the latency
    alof_smp_t pipe_r [LATENCY];

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < LATENCY; i++)
                pipe_r[i] <= '0;
        end
        else if (clk_en && take)
        begin
            pipe_r[0] <= quant_in;
            for (int i = 1; i < LATENCY; i++)
                pipe_r[i] <= pipe_r[i-1];
        end
    end

    // output stage: word and flag change together, clock rises a cycle later
    wire alof_smp_t tail     = pipe_r[LATENCY-1];
    wire [7:0]      out_nxt  = fmt_word(sat_code(tail), offs_fmt);
    wire            rng_nxt  = tail.over | tail.under;
    logic [7:0]     word_r;
    logic           rng_r;
    logic           dclk_r;
    logic           upd_r;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            word_r <= fmt_word(CODE_BOTTOM, 1'b1);
            rng_r  <= 1'b0;
            upd_r  <= 1'b0;
            dclk_r <= 1'b0;
        end
        else if (clk_en)
        begin
            upd_r <= take;
            if (take)
            begin
                word_r <= out_nxt;
                rng_r  <= rng_nxt;
            end
            // rising after the data settles gives the receiver its setup
            if (upd_r)
                dclk_r <= 1'b1;
            else if (fall_t)
                dclk_r <= 1'b0;
        end
    end

    // differential pairs are registered copies, never gates on the pins
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sample_word_pairs_true <= 8'h00;
            sample_word_pairs_comp <= 8'hff;
            range_flag_true        <= 1'b0;
            range_flag_comp        <= 1'b1;
            data_clock_out_true    <= 1'b0;
            data_clock_out_comp    <= 1'b1;
        end
        else if (clk_en)
        begin
            sample_word_pairs_true <= word_r;
            sample_word_pairs_comp <= ~word_r;
            range_flag_true        <= rng_r;
            range_flag_comp        <= ~rng_r;
            data_clock_out_true    <= dclk_r;
            data_clock_out_comp    <= ~dclk_r;
        end
    end

    // events seen by software
    logic [31:0]      word_cnt_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    wire  [IRQ_W-1:0] irq_evt;
    assign irq_evt[IRQ_WORD_BIT]  = take;
    assign irq_evt[IRQ_RANGE_BIT] = take & rng_nxt;

    // apb decode: access completes in the cycle pready is high
    wire        setup_ph  = apb_req.psel & ~apb_req.penable;
    wire        access_ok = apb_req.psel & apb_req.penable & pready;
    wire        wr_acc    = access_ok & apb_req.pwrite;
    wire [7:0]  adr       = apb_req.paddr;
    wire        hit_ctrl  = (adr == OFS_CTRL);
    wire        hit_stat  = (adr == OFS_STATUS);
    wire        hit_istat = (adr == OFS_IRQ_STAT);
    wire        hit_ien   = (adr == OFS_IRQ_EN);
    wire        hit_iclr  = (adr == OFS_IRQ_CLR);
    wire        hit_cnt   = (adr == OFS_WORD_CNT);
    wire        mapped    = hit_ctrl | hit_stat | hit_istat | hit_ien | hit_iclr | hit_cnt;
    // writes to read only words are refused as errors as well
    wire        wr_bad    = apb_req.pwrite & (hit_stat | hit_istat | hit_cnt);
    wire [IRQ_W-1:0] clr_mask = (wr_acc & hit_iclr) ? apb_req.pwdata[IRQ_W-1:0] : '0;

    // read mux, status shows the live output state
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux[CTRL_RUN_BIT] = run_r;
        else if (hit_stat)
        begin
            rd_mux[WORD_W-1:0]   = word_r;
            rd_mux[ST_RANGE_BIT] = rng_r;
            rd_mux[ST_HALF_BIT]  = half_mode;
            rd_mux[ST_OFFS_BIT]  = offs_fmt;
        end
        else if (hit_istat)
            rd_mux[IRQ_W-1:0] = irq_stat_r;
        else if (hit_ien)
            rd_mux[IRQ_W-1:0] = irq_en_r;
        else if (hit_cnt)
            rd_mux = word_cnt_r;
    end

    // bus handshake: one wait-free access phase after each setup
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready  <= setup_ph;
            if (setup_ph)
            begin
                prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~mapped | wr_bad;
            end
            else if (access_ok)
            begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // software registers; a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            run_r      <= CTRL_RUN_RST;
            irq_en_r   <= IRQ_EN_RST;
            irq_stat_r <= '0;
            word_cnt_r <= 32'h0000_0000;
            irq        <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_acc && hit_ctrl)
                run_r <= apb_req.pwdata[CTRL_RUN_BIT];
            if (wr_acc && hit_ien)
                irq_en_r <= apb_req.pwdata[IRQ_W-1:0];
            irq_stat_r <= (irq_stat_r & ~clr_mask) | irq_evt;
            if (take)
                word_cnt_r <= word_cnt_r + 32'h0000_0001;
            irq <= |(((irq_stat_r & ~clr_mask) | irq_evt) & irq_en_r);
        end
    end

endmodule

`default_nettype wire

//--- core/alof_pkg.sv
`default_nettype none

package alof_pkg;

    // widths and pipeline depth
    localparam int          WORD_W         = 8;
    localparam int          PIPE_LATENCY   = 9;
    localparam int          APB_AW         = 8;

    // saturation codes in offset binary
    localparam logic [7:0]  CODE_TOP       = 8'hff;
    localparam logic [7:0]  CODE_BOTTOM    = 8'h00;
    localparam int          MSB_POS        = 7;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STATUS     = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h08;
    localparam logic [7:0]  OFS_IRQ_EN     = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_CLR    = 8'h10;
    localparam logic [7:0]  OFS_WORD_CNT   = 8'h14;

    // field positions
    localparam int          CTRL_RUN_BIT   = 0;
    localparam int          ST_RANGE_BIT   = 8;
    localparam int          ST_HALF_BIT    = 9;
    localparam int          ST_OFFS_BIT    = 10;
    localparam int          IRQ_W          = 2;
    localparam int          IRQ_WORD_BIT   = 0;
    localparam int          IRQ_RANGE_BIT  = 1;

    // reset values
    localparam logic        CTRL_RUN_RST   = 1'b1;
    localparam logic [1:0]  IRQ_EN_RST     = 2'h0;

    // one converted result travelling down the pipeline
    typedef struct packed {
        logic               over;
        logic               under;
        logic [7:0]         code;
    } alof_smp_t;

    // apb request from the master
    typedef struct packed {
        logic [7:0]         paddr;
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [31:0]        pwdata;
    } alof_apb_req_t;

endpackage

`default_nettype wire

//--- verif/alof_core_test.sv
`default_nettype none

module alof_core_test
    import alof_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // stimulus; half and format start at 0 like open pins with pulldowns
    logic          ref_clk = 1'b0;
    logic          sys_rst = 1'b1;
    logic          sc_r = 1'b0;
    logic          half_r = 1'b0;
    logic          fmt_r = 1'b0;
    alof_smp_t     q_r = '0;
    alof_apb_req_t req_r = '0;
    // design outputs and receiver view
    logic          pready, pslverr, irq, rt, dt, cr, err_r;
    logic [31:0]   prdata, rd_r;
    logic [7:0]    wt, cw;
    int            cn, fail_count = 0, checks_done = 0;

    always #5 ref_clk = ~ref_clk;

    alof_core dut (.ref_clk, .sys_rst, .clk_en(1'b1), .sample_clock_true(sc_r),
        .sample_clock_comp(~sc_r), .half_rate_select(half_r), .format_select(fmt_r),
        .quant_in(q_r), .apb_req(req_r), .pready, .prdata, .pslverr, .irq,
        .sample_word_pairs_true(wt), .sample_word_pairs_comp(), .range_flag_true(rt),
        .range_flag_comp(), .data_clock_out_true(dt), .data_clock_out_comp());

    alof_rx_model rx (.dclk(dt), .word(wt), .rng(rt), .cap_word(cw), .cap_rng(cr), .cap_cnt(cn));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; ready is read at the edge where it is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req_r <= '{a, 1'b1, 1'b0, wr, d};
        @(posedge ref_clk);
        req_r.penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            fail_count++;
        rd_r = prdata;
        err_r = pslverr;
        req_r <= '0;
        @(posedge ref_clk);
    endtask

    // n sample clock periods, six system cycles per level so the synchroniser keeps up
    task automatic per(input alof_smp_t q, input int n);
        repeat (n)
        begin
            q_r <= q;
            // steady free period, each level held for six system cycles
            sc_r <= 1'b1;
            repeat (6) @(posedge ref_clk);
            sc_r <= 1'b0;
            repeat (6) @(posedge ref_clk);
        end
    endtask

    // saturate, then flip the top bit for two's complement
    function automatic logic [7:0] expw(input alof_smp_t q, input logic f);
        logic [7:0] s;
        s = q.over ? CODE_TOP : (q.under ? CODE_BOTTOM : q.code);
        return f ? s : {~s[7], s[6:0]};
    endfunction

    task automatic t_regs;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd_r, 32'h1); // run set at reset
        apb(1'b0, OFS_IRQ_EN, 32'h0);
        chk(rd_r, 32'h0); // enables clear at reset
        apb(1'b0, 8'h18, 32'h0);
        chk(err_r, 32'h1); // unmapped address
        apb(1'b1, OFS_STATUS, 32'hff);
        chk(err_r, 32'h1); // read-only register
        $display("regs test done");
    endtask

    task automatic t_rate;
        int c0;
        logic [31:0] w0;
        apb(1'b0, OFS_WORD_CNT, 32'h0);
        w0 = rd_r;
        c0 = cn;
        per('{1'b0, 1'b0, 8'h40}, 10);
        chk(cn - c0, 32'd5);
        apb(1'b0, OFS_WORD_CNT, 32'h0);
        chk(rd_r - w0, 32'd5);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd_r[ST_HALF_BIT], 32'h1);
        half_r <= 1'b1;
        c0 = cn;
        per('{1'b0, 1'b0, 8'h40}, 10);
        chk(cn - c0, 32'd10);
        apb(1'b0, OFS_WORD_CNT, 32'h0);
        chk(rd_r - w0, 32'd15);
        apb(1'b1, OFS_CTRL, 32'h0);
        c0 = cn;
        per('{1'b0, 1'b0, 8'h40}, 4);
        chk(cn - c0, 32'd0);
        apb(1'b1, OFS_CTRL, 32'h1);
        $display("rate test done");
    endtask

    task automatic t_codes;
        alof_smp_t tbl [4];
        tbl = '{'{1'b0, 1'b0, 8'h3c}, '{1'b1, 1'b0, 8'h55},
                '{1'b0, 1'b1, 8'h55}, '{1'b0, 1'b0, 8'h80}};
        for (int f = 0; f < 2; f++)
            for (int i = 0; i < 4; i++)
            begin
                fmt_r <= f[0];
                per(tbl[i], 11);
                chk(cw, expw(tbl[i], f[0]));
                chk(cr, tbl[i].over | tbl[i].under);
                apb(1'b0, OFS_STATUS, 32'h0);
                chk(rd_r[ST_OFFS_BIT:0], {f[0], 1'b0, tbl[i].over | tbl[i].under,
                    expw(tbl[i], f[0])});
            end
        $display("codes test done");
    endtask

    task automatic t_latency;
        per('{1'b0, 1'b0, 8'h11}, 10);
        per('{1'b0, 1'b0, 8'h22}, 9);
        chk(cw, expw('{1'b0, 1'b0, 8'h11}, fmt_r));
        per('{1'b0, 1'b0, 8'h22}, 1);
        chk(cw, expw('{1'b0, 1'b0, 8'h22}, fmt_r));
        $display("latency test done");
    endtask

    task automatic t_irq;
        apb(1'b1, OFS_IRQ_EN, 32'h2);
        per('{1'b1, 1'b0, 8'h00}, 10);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(rd_r[IRQ_RANGE_BIT], 32'h1);
        chk(irq, 32'h1); // enabled event raises the line
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        // the line follows the enable one cycle after the write lands
        @(posedge ref_clk);
        chk(irq, 32'h0); // masked
        apb(1'b1, OFS_IRQ_EN, 32'h2);
        per('{1'b0, 1'b0, 8'h10}, 10);
        chk(irq, 32'h1); // sticky after the condition ends
        apb(1'b1, OFS_IRQ_CLR, 32'h3);
        @(posedge ref_clk);
        chk(irq, 32'h0); // cleared
        $display("irq test done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_regs;
        t_rate;
        t_codes;
        t_latency;
        t_irq;
        give_verdict;
    end

    // the whole run needs under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        give_verdict;
    end
endmodule

bind alof_core alof_props u_props (.ref_clk, .sys_rst, .apb_req, .pready, .pslverr,
    .sample_word_pairs_true, .sample_word_pairs_comp, .range_flag_true, .range_flag_comp,
    .data_clock_out_true, .data_clock_out_comp);

`default_nettype wire

//--- verif/alof_props.sv
`default_nettype none

module alof_props
    import alof_pkg::*;
(
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          sys_rst,
    // register bus
    input wire alof_apb_req_t apb_req,
    input wire logic          pready,
    input wire logic          pslverr,
    // output pairs
    input wire logic [7:0]    sample_word_pairs_true,
    input wire logic [7:0]    sample_word_pairs_comp,
    input wire logic          range_flag_true,
    input wire logic          range_flag_comp,
    input wire logic          data_clock_out_true,
    input wire logic          data_clock_out_comp
);
    timeunit 1ns;
    timeprecision 1ps;

    // one clock domain, so one default clock and disable
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // each lvds pair must stay complementary
    a_word_inv: assert property (sample_word_pairs_comp == ~sample_word_pairs_true)
        else $error("word pair not complementary");
    a_range_inv: assert property (range_flag_comp == ~range_flag_true)
        else $error("range pair not complementary");
    a_dclk_inv: assert property (data_clock_out_comp == ~data_clock_out_true)
        else $error("data clock pair not complementary");
    // new data lands one cycle ahead of the forwarded clock rise
    a_word_then_dclk: assert property ($changed(sample_word_pairs_true) |=>
        $rose(data_clock_out_true)) else $error("word changed without clock rise");
    a_range_with_word: assert property ($changed(range_flag_true) |=>
        $rose(data_clock_out_true)) else $error("range changed off the data clock");
    // receiver latches on the rise, so data must hold while the clock is high
    a_word_stands: assert property (data_clock_out_true |->
        $stable(sample_word_pairs_true) && $stable(range_flag_true))
        else $error("data moved while data clock high");
    // zero wait state slave: one ready pulse per access
    a_ready_setup: assert property (apb_req.psel && !apb_req.penable |=> pready) // zero wait
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready) // single access cycle
        else $error("ready held too long");
    a_err_access: assert property (pslverr |-> pready && apb_req.penable) // qualified error
        else $error("error outside access cycle");

    // main scenarios reached
    c_dclk: cover property ($rose(data_clock_out_true));
    c_range: cover property ($rose(range_flag_true));
    c_err: cover property (pslverr);
endmodule

`default_nettype wire

//--- verif/alof_rx_model.sv
`default_nettype none

// far-end receiver: latches what the converter forwards
module alof_rx_model
(
    // forwarded clock and data pins
    input  wire logic       dclk,
    input  wire logic [7:0] word,
    input  wire logic       rng,
    // captured values
    output logic [7:0]      cap_word,
    output logic            cap_rng,
    output int              cap_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    // one process owns the count, the port only mirrors it
    int cnt_r = 0;
    assign cap_cnt = cnt_r;

    // capture on the forwarded clock only, never on the system clock
    always @(posedge dclk)
    begin
        cap_word <= word;
        cap_rng  <= rng;
        cnt_r    <= cnt_r + 1;
    end
endmodule

`default_nettype wire
